// >>> hdl/i2css_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module i2css_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;
  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem[rp_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// >>> hdl/i2css_top.sv
// i2c slave controller with start/stop monitor
`timescale 1ns/1ps
`include "i2css_params.svh"
// Summary of operation
// - slave drives sda from its data whenever transmitting, regardless of pin directions
// - after matched address or data byte, ack automatically then load buffer
// - buffer full or overflow set: no ack except for a read address, no load, irq still set
// - reading buffer clears full flag; software alone clears overflow
// - after enable wait for start, shift 8 bits on rising scl
// - compare shift bits 7:1 with own address 7:1 on eighth falling scl
// - match with flags clear: load, set full, ack, irq on ninth fall
// - 10-bit first byte is 11110 A9 A8 0
// - high address byte sets irq, full, update flag and stretches scl
// - low byte sets same flags; address rewrite releases scl and clears update
// - matched write address clears read_write and buffers the address
// - matched read address sets read_write, acks, then holds scl low
// - transmit bits change on falling scl so sda stable while high
// - irq set on ninth falling edge for every byte of a matched transfer except a transmit byte the master nacks; software clears
// - master ack latched on ninth rise; nack ends transfer, back to idle
// - start and stop flags cleared on reset and disable, track bus
// - firmware-master modes raise irq on start and stop; 1110 and 1111 also on each byte
// - mode 1011 gives start/stop irqs with slave matching idle
// - after lost arbitration slave keeps receiving and acks own address
// - scl forced low while release bit clear; freed when others release
// - enabled i2c mode drives scl and sda open drain
// - all slave functions except general call recognition, a compare of the 10-bit low address byte and of A9 A8 in a 10-bit read high byte
module i2css_top
  import i2css_pkg::*;
#(
  parameter int FIFO_DEPTH = `I2CSS_FIFO_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        scl_in,
  output logic             scl_oe_n,
  output logic             scl_out,
  input  wire logic        sda_in,
  output logic             sda_oe_n,
  output logic             sda_out,
  input  wire logic        port_enable_bit,
  input  wire logic [3:0]  port_mode_select,
  input  wire logic [7:0]  own_address_wdata,
  input  wire logic        own_address_we,
  input  wire logic [7:0]  tx_wdata,
  input  wire logic        tx_we,
  input  wire logic        clock_release_set,
  input  wire logic        irq_clear,
  input  wire logic        overflow_clear,
  output logic [7:0]       rx_data,
  output logic             rx_valid,
  input  wire logic        rx_ready,
  output i2css_status_t    status
);
  // ****************************************
  // bus synchronisers and condition detect
  // ****************************************
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic       scl_d_r;
  logic       sda_d_r;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_d_r    <= 1'b1;
      sda_d_r    <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[0], scl_in};
      sda_sync_r <= {sda_sync_r[0], sda_in};
      scl_d_r    <= scl_sync_r[1];
      sda_d_r    <= sda_sync_r[1];
    end
  end
  wire scl_s    = scl_sync_r[1];
  wire sda_s    = sda_sync_r[1];
  wire scl_rise = scl_s && !scl_d_r;
  wire scl_fall = !scl_s && scl_d_r;
  wire start_c  = scl_s && scl_d_r && sda_d_r && !sda_s;
  wire stop_c   = scl_s && scl_d_r && !sda_d_r && sda_s;

  wire mode_ok    = (port_mode_select == `I2CSS_MODE_SLV7) || (port_mode_select == `I2CSS_MODE_SLV10) ||
                    (port_mode_select == `I2CSS_MODE_FWM_IDLE) || (port_mode_select == `I2CSS_MODE_SLV7_SP) ||
                    (port_mode_select == `I2CSS_MODE_SLV10_SP);
  wire en         = port_enable_bit && mode_ok;
  wire slave_on   = en && (port_mode_select != `I2CSS_MODE_FWM_IDLE);
  wire sp_irq_on  = en && (port_mode_select == `I2CSS_MODE_FWM_IDLE || port_mode_select == `I2CSS_MODE_SLV7_SP ||
                    port_mode_select == `I2CSS_MODE_SLV10_SP);
  wire ten_bit    = (port_mode_select == `I2CSS_MODE_SLV10) || (port_mode_select == `I2CSS_MODE_SLV10_SP);

  // ****************************************
  // slave byte engine
  // ****************************************
  i2css_state_t state_r;
  logic [7:0]   shift_r;
  logic [3:0]   bitcnt_r;
  logic         ack_r;
  logic         addr_phase_r;
  logic         ten_low_r;
  logic         ten_ok_r;
  logic         matched_r;
  logic         byte_done_r;
  logic         tx_byte_r;
  logic [7:0]   addr_r;
  logic [7:0]   buf_r;
  logic         rw_r;
  logic         ua_r;
  logic         bf_r;
  logic         ov_r;
  logic         irq_r;
  logic         ckp_r;
  logic         ss_r;
  logic         ps_r;
  logic         push_nxt;
  logic         push_ready;

  // no general call: address 0 never matches
  wire        gc     = (shift_r[7:1] == 7'h00);
  wire        m7     = (shift_r[7:1] == addr_r[7:1]) && !gc;
  wire        m10hi  = (shift_r[7:3] == `I2CSS_TEN_PREFIX);
  wire        full   = bf_r || ov_r || !push_ready;
  wire        at8    = (bitcnt_r == `I2CSS_BITS_PER_BYTE);
  wire        take_byte = scl_fall && at8 && (state_r == I2CSS_RX);

  always_ff @(posedge clk) begin
    if (!reset_n || !slave_on) begin
      state_r      <= I2CSS_IDLE;
      shift_r      <= 8'h00;
      bitcnt_r     <= 4'h0;
      ack_r        <= 1'b0;
      addr_phase_r <= 1'b0;
      ten_low_r    <= 1'b0;
      ten_ok_r     <= 1'b0;
      matched_r    <= 1'b0;
      tx_byte_r    <= 1'b0;
      byte_done_r  <= 1'b0;
      push_nxt     <= 1'b0;
    end else begin
      byte_done_r <= 1'b0;
      push_nxt    <= 1'b0;
      if (start_c) begin
        state_r      <= I2CSS_RX;
        bitcnt_r     <= 4'h0;
        addr_phase_r <= 1'b1;
        ten_low_r    <= 1'b0;
        ack_r        <= 1'b0;
      end else if (stop_c) begin
        state_r   <= I2CSS_IDLE;
        matched_r <= 1'b0;
        ten_ok_r  <= 1'b0;
        ack_r     <= 1'b0;
      end else begin
        case (state_r)
          I2CSS_IDLE: begin
            bitcnt_r <= 4'h0;
          end
          I2CSS_RX: begin
            if (scl_rise && !at8) begin
              shift_r  <= {shift_r[6:0], sda_s};
              bitcnt_r <= bitcnt_r + 4'h1;
            end
            if (take_byte) begin
              bitcnt_r <= 4'h0;
              if (addr_phase_r && !ten_low_r) begin
                if (ten_bit && m10hi && !shift_r[0] && (shift_r[2:1] == addr_r[2:1])) begin
                  ack_r     <= !full;
                  ten_low_r <= 1'b1;
                  push_nxt  <= !full;
                  state_r   <= I2CSS_ACK;
                end else if (ten_bit && m10hi && shift_r[0] && ten_ok_r) begin
                  ack_r     <= 1'b1;
                  tx_byte_r <= 1'b1;
                  push_nxt  <= !full;
                  state_r   <= I2CSS_ACK;
                end else if (!ten_bit && m7) begin
                  ack_r     <= !full || shift_r[0];
                  tx_byte_r <= shift_r[0];
                  push_nxt  <= !full;
                  matched_r <= 1'b1;
                  state_r   <= I2CSS_ACK;
                end else begin
                  state_r <= I2CSS_IDLE;
                end
              end else if (addr_phase_r) begin
                ack_r    <= !full;
                push_nxt <= !full;
                ten_ok_r <= 1'b1;
                state_r  <= I2CSS_ACK;
              end else begin
                ack_r    <= !full;
                push_nxt <= !full;
                state_r  <= I2CSS_ACK;
              end
            end
          end
          I2CSS_ACK: begin
            if (scl_fall) begin
              byte_done_r  <= 1'b1;
              ack_r        <= 1'b0;
              addr_phase_r <= ten_low_r && addr_phase_r && !ten_ok_r;
              state_r      <= tx_byte_r ? I2CSS_HOLD : I2CSS_RX;
            end
          end
          I2CSS_HOLD: begin
            if (ckp_r) begin
              state_r  <= I2CSS_TX;
              shift_r  <= buf_r;
              bitcnt_r <= 4'h0;
            end
          end
          I2CSS_TX: begin
            if (scl_fall) begin
              shift_r  <= {shift_r[6:0], 1'b1};
              bitcnt_r <= bitcnt_r + 4'h1;
              if (bitcnt_r == `I2CSS_BITS_PER_BYTE - 4'h1) begin
                state_r <= I2CSS_MACK;
              end
            end
          end
          I2CSS_MACK: begin
            if (scl_rise) begin
              if (sda_s) begin
                state_r   <= I2CSS_IDLE;
                tx_byte_r <= 1'b0;
                matched_r <= 1'b0;
              end
            end else if (scl_fall) begin
              byte_done_r <= 1'b1;
              state_r     <= I2CSS_HOLD;
            end
          end
          default: begin
            state_r <= I2CSS_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************
  // status flags
  // ****************************************
  always_ff @(posedge clk) begin
    if (!reset_n || !en) begin
      ss_r <= 1'b0;
      ps_r <= 1'b0;
    end else if (start_c) begin
      ss_r <= 1'b1;
      ps_r <= 1'b0;
    end else if (stop_c) begin
      ss_r <= 1'b0;
      ps_r <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || !en) begin
      irq_r <= 1'b0;
    end else if ((start_c || stop_c) && sp_irq_on) begin
      irq_r <= 1'b1;
    end else if (byte_done_r) begin
      // ninth fall only, so a foreign 7-bit address or 10-bit write high byte raises nothing
      irq_r <= 1'b1;
    end else if (irq_clear) begin
      irq_r <= 1'b0;
    end
  end

  // buffer full set on each push; a read of buffer is a handshake on the rx output register
  wire rx_pop = rx_valid && rx_ready;
  always_ff @(posedge clk) begin
    if (!reset_n || !en) begin
      bf_r <= 1'b0;
      ov_r <= 1'b0;
    end else begin
      // an ack phase without ack is always a refused byte
      if (state_r == I2CSS_ACK && scl_fall && !ack_r) begin
        ov_r <= 1'b1;
      end else if (overflow_clear) begin
        ov_r <= 1'b0;
      end
      if (push_nxt) begin
        bf_r <= 1'b1;
      end else if (rx_pop) begin
        bf_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      addr_r <= 8'h00;
      ua_r   <= 1'b0;
      rw_r   <= 1'b0;
      buf_r  <= 8'h00;
    end else begin
      if (own_address_we) begin
        addr_r <= own_address_wdata;
      end
      if (!slave_on || (state_r == I2CSS_MACK && scl_rise && sda_s)) begin
        rw_r <= 1'b0;
      end else if (take_byte && addr_phase_r && !ten_low_r && (m7 || m10hi)) begin
        rw_r <= shift_r[0];
      end
      if (push_nxt && ten_bit && addr_phase_r) begin
        ua_r <= 1'b1;
      end else if (own_address_we) begin
        ua_r <= 1'b0;
      end
      if (tx_we) begin
        buf_r <= tx_wdata;
      end else if (push_nxt) begin
        buf_r <= shift_r;
      end
    end
  end

  // ****************************************
  // clock stretch and pin drive
  // ****************************************
  // update stretch waits for the ack bit to end, else the ninth clock never rises
  wire stretch_req = ((state_r == I2CSS_HOLD) && !ckp_r) ||
                     (ua_r && state_r != I2CSS_IDLE && state_r != I2CSS_ACK);
  always_ff @(posedge clk) begin
    if (!reset_n || !en) begin
      ckp_r <= 1'b1;
    end else if (clock_release_set) begin
      ckp_r <= 1'b1;
    end else if (state_r == I2CSS_ACK && scl_fall && tx_byte_r) begin
      ckp_r <= 1'b0;
    end else if (state_r == I2CSS_MACK && scl_fall) begin
      ckp_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || !en) begin
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
    end else begin
      // only pull scl once already low so a stretch never shortens a high phase
      scl_oe_n <= !(stretch_req && (!scl_s || !scl_oe_n));
      sda_oe_n <= !((state_r == I2CSS_ACK && ack_r) || (state_r == I2CSS_TX && !shift_r[7]));
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      status  <= '0;
    end else begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      status  <= '{ss_r, ps_r, rw_r, ua_r, bf_r, ov_r, irq_r, ckp_r};
    end
  end

  // ****************************************
  // receive fifo
  // ****************************************
  logic [7:0] fifo_out;
  logic       fifo_valid;
  logic       fifo_pop;
  i2css_fifo #(
    .WIDTH (`I2CSS_BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) i_i2css_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_data   (shift_r),
    .in_valid  (push_nxt),
    .in_ready  (push_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );
  // output register stage keeps rx outputs straight from flops
  assign fifo_pop = fifo_valid && (!rx_valid || rx_ready);
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rx_valid <= 1'b0;
      rx_data  <= 8'h00;
    end else if (fifo_pop) begin
      rx_valid <= 1'b1;
      rx_data  <= fifo_out;
    end else if (rx_ready) begin
      rx_valid <= 1'b0;
    end
  end
endmodule

// >>> shared/i2css_params.svh
// constants for the i2c slave start/stop monitor
`ifndef I2CSS_PARAMS_SVH
`define I2CSS_PARAMS_SVH
`define I2CSS_MODE_SLV7      4'h6
`define I2CSS_MODE_SLV10     4'h7
`define I2CSS_MODE_FWM_IDLE  4'hB
`define I2CSS_MODE_SLV7_SP   4'hE
`define I2CSS_MODE_SLV10_SP  4'hF
`define I2CSS_TEN_PREFIX     5'h1E
`define I2CSS_BITS_PER_BYTE  4'h8
`define I2CSS_FIFO_DEPTH     8
`define I2CSS_BYTE_W         8
`endif

// >>> shared/i2css_pkg.sv
// types for the i2c slave start/stop monitor
package i2css_pkg;
  typedef enum logic [5:0] {
    I2CSS_IDLE  = 6'h01,
    I2CSS_RX    = 6'h02,
    I2CSS_ACK   = 6'h04,
    I2CSS_TX    = 6'h08,
    I2CSS_MACK  = 6'h10,
    I2CSS_HOLD  = 6'h20
  } i2css_state_t;
  typedef struct packed {
    logic start_seen;
    logic stop_seen;
    logic read_write;
    logic addr_update;
    logic buf_full;
    logic overflow;
    logic irq;
    logic clk_release;
  } i2css_status_t;
endpackage

// >>> verif/i2css_master.sv
// i2c bus master model pulling scl and sda low through open-drain
`timescale 1ns/1ps
module i2css_master (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_pull,
  output logic      sda_pull
);
  int stuck;
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    stuck = 0;
  end
  // bounded, so a slave that never frees scl shows up instead of hanging
  task automatic wait_scl_high();
    int n;
    n = 0;
    while (scl !== 1'b1 && n < 4000) begin
      #5;
      n++;
    end
    if (n >= 4000) stuck++;
  endtask
  // data set mid low phase, sampled late in the high phase
  task automatic bit_cycle(input logic low, output logic seen);
    sda_pull = low;
    #20;
    scl_pull = 1'b0;
    wait_scl_high();
    #40;
    seen = sda;
    scl_pull = 1'b1;
    #20;
  endtask
  task automatic start_cond();
    sda_pull = 1'b0;
    #20;
    scl_pull = 1'b0;
    wait_scl_high();
    #40;
    sda_pull = 1'b1;
    #40;
    scl_pull = 1'b1;
    #20;
  endtask
  task automatic stop_cond();
    sda_pull = 1'b1;
    #20;
    scl_pull = 1'b0;
    wait_scl_high();
    #40;
    sda_pull = 1'b0;
    #40;
  endtask
  task automatic send_byte(input logic [7:0] b, output logic acked);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(!b[i], s);
      // a high bit read back low is lost arbitration, counted as a fault
      if (b[i] && !s) stuck++;
    end
    bit_cycle(1'b0, s);
    acked = !s;
    #60;
  endtask
  task automatic recv_byte(output logic [7:0] b, input logic give_ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b0, s);
      b[i] = s;
    end
    bit_cycle(give_ack, s);
    sda_pull = 1'b0;
    #60;
  endtask
endmodule

// >>> verif/i2css_props.sv
// concurrent checks on the ports of the i2c slave start/stop monitor
`timescale 1ns/1ps
module i2css_props
  import i2css_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic          clk,
  input wire logic          reset_n,
  input wire logic          scl_in,
  input wire logic          scl_oe_n,
  input wire logic          scl_out,
  input wire logic          sda_in,
  input wire logic          sda_oe_n,
  input wire logic          sda_out,
  input wire logic          port_enable_bit,
  input wire logic          own_address_we,
  input wire logic          clock_release_set,
  input wire logic          irq_clear,
  input wire logic          overflow_clear,
  input wire i2css_status_t status
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_OPEN_DRAIN: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("pin data not low");
  AST_DISABLE_CLEARS: assert property (!port_enable_bit [*3] |-> !status.start_seen && !status.stop_seen)
    else $error("bus flags kept while disabled");
  AST_START_SEEN: assert property ($fell(sda_in) && scl_in && port_enable_bit |-> ##[1:8] status.start_seen)
    else $error("start not flagged");
  AST_STOP_SEEN: assert property ($rose(sda_in) && scl_in && port_enable_bit |-> ##[1:8] status.stop_seen)
    else $error("stop not flagged");
  AST_OVF_STICKY: assert property (status.overflow && !overflow_clear && !$past(overflow_clear) && port_enable_bit
    |=> status.overflow)
    else $error("overflow cleared by hardware");
  AST_NO_ACK_OVF: assert property (status.overflow && !status.read_write |-> sda_oe_n)
    else $error("sda driven during overflow");
  AST_IRQ_STICKY: assert property (status.irq && !irq_clear && !$past(irq_clear) && port_enable_bit
    |=> status.irq)
    else $error("irq dropped without clear");
  AST_HOLD_SCL: assert property (port_enable_bit && $past(port_enable_bit, 2) && $past(reset_n)
    && !status.clk_release && !$past(status.clk_release) |-> !scl_oe_n) else $error("scl not held");
  AST_RELEASE_BIT: assert property (clock_release_set && port_enable_bit |-> ##2 status.clk_release)
    else $error("release bit not set");
  AST_UA_CLEAR: assert property (own_address_we && port_enable_bit |-> ##2 !status.addr_update)
    else $error("update flag not cleared");
  AST_SDA_STEADY: assert property (status.read_write && scl_in && $past(scl_in) && $past(scl_in, 2)
    && $past(scl_in, 3) |-> $stable(sda_oe_n)) else $error("sda moved while scl high");
endmodule
bind i2css_top i2css_props #(.FIFO_DEPTH(FIFO_DEPTH)) i_i2css_props (
  .clk(clk), .reset_n(reset_n), .scl_in(scl_in), .scl_oe_n(scl_oe_n), .scl_out(scl_out),
  .sda_in(sda_in), .sda_oe_n(sda_oe_n), .sda_out(sda_out), .port_enable_bit(port_enable_bit),
  .own_address_we(own_address_we), .clock_release_set(clock_release_set), .irq_clear(irq_clear),
  .overflow_clear(overflow_clear), .status(status));

// >>> verif/i2css_top_test.sv
// self-checking bench for the i2c slave start/stop monitor
`timescale 1ns/1ps
`include "i2css_params.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; $display("wrong value %s exp %0h got %0h", nm, (e), (g)); end end
module i2css_top_test
  import i2css_pkg::*;
();
  logic          clk, reset_n, port_enable_bit, own_address_we, tx_we, clock_release_set;
  logic          irq_clear, overflow_clear, rx_ready, scl_oe_n, scl_out, sda_oe_n, sda_out, rx_valid;
  logic [3:0]    port_mode_select;
  logic [7:0]    own_address_wdata, tx_wdata, rx_data, got;
  i2css_status_t status;
  logic          m_scl_pull, m_sda_pull, scl_w, sda_w, ack;
  int            n_fail, tests_run, cycles;
  // pull-ups: a released line reads high
  assign scl_w = (scl_oe_n ? 1'b1 : scl_out) & ~m_scl_pull;
  assign sda_w = (sda_oe_n ? 1'b1 : sda_out) & ~m_sda_pull;
  i2css_top #(.FIFO_DEPTH(`I2CSS_FIFO_DEPTH)) i_i2css_top (
    .clk(clk), .reset_n(reset_n), .scl_in(scl_w), .scl_oe_n(scl_oe_n), .scl_out(scl_out),
    .sda_in(sda_w), .sda_oe_n(sda_oe_n), .sda_out(sda_out), .port_enable_bit(port_enable_bit),
    .port_mode_select(port_mode_select), .own_address_wdata(own_address_wdata),
    .own_address_we(own_address_we), .tx_wdata(tx_wdata), .tx_we(tx_we),
    .clock_release_set(clock_release_set), .irq_clear(irq_clear), .overflow_clear(overflow_clear),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .status(status));
  i2css_master i_i2css_master (.scl(scl_w), .sda(sda_w), .scl_pull(m_scl_pull), .sda_pull(m_sda_pull));
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks run %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic cyc();
    @(posedge clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc();
    s = 1'b0;
    cyc();
  endtask
  task automatic set_addr(input logic [7:0] a);
    own_address_wdata = a;
    pulse(own_address_we);
  endtask
  task automatic read_buf(input logic [7:0] e);
    for (int n = 0; n < 50 && rx_valid !== 1'b1; n++) cyc();
    `CHK("rx_data", e, rx_data)
    rx_ready = 1'b1;
    cyc();
    rx_ready = 1'b0;
    repeat (2) cyc();
    `CHK("buf_full after read", 1'b0, status.buf_full)
    pulse(irq_clear);
  endtask
  task automatic t_write();
    set_addr(8'hA5);
    i_i2css_master.start_cond();
    `CHK("start_seen", 1'b1, status.start_seen)
    i_i2css_master.send_byte(8'hA4, ack);
    `CHK("addr ack", 1'b1, ack)
    `CHK("read_write", 1'b0, status.read_write)
    `CHK("buf_full", 1'b1, status.buf_full)
    `CHK("irq", 1'b1, status.irq)
    read_buf(8'hA4);
    i_i2css_master.send_byte(8'h3C, ack);
    `CHK("data ack", 1'b1, ack)
    `CHK("irq data", 1'b1, status.irq)
    i_i2css_master.send_byte(8'h77, ack);
    `CHK("ack when full", 1'b0, ack)
    `CHK("overflow", 1'b1, status.overflow)
    read_buf(8'h3C);
    `CHK("overflow kept", 1'b1, status.overflow)
    i_i2css_master.send_byte(8'h11, ack);
    `CHK("ack on overflow", 1'b0, ack)
    `CHK("irq on overflow", 1'b1, status.irq)
    pulse(overflow_clear);
    `CHK("overflow cleared", 1'b0, status.overflow)
    i_i2css_master.stop_cond();
    `CHK("stop_seen", 1'b1, status.stop_seen)
  endtask
  task automatic t_mismatch();
    `CHK("bus free", 1'b1, status.stop_seen)
    pulse(irq_clear);
    i_i2css_master.start_cond();
    i_i2css_master.send_byte(8'hB4, ack);
    `CHK("foreign addr ack", 1'b0, ack)
    `CHK("foreign addr irq", 1'b0, status.irq)
    i_i2css_master.start_cond();
    i_i2css_master.send_byte(8'h00, ack);
    `CHK("general call ack", 1'b0, ack)
    i_i2css_master.stop_cond();
    `CHK("rx_valid", 1'b0, rx_valid)
  endtask
  task automatic t_read();
    i_i2css_master.start_cond();
    i_i2css_master.send_byte(8'hA5, ack);
    `CHK("read addr ack", 1'b1, ack)
    `CHK("read_write", 1'b1, status.read_write)
    repeat (20) cyc();
    `CHK("scl stretched", 1'b0, scl_oe_n)
    `CHK("clk_release", 1'b0, status.clk_release)
    read_buf(8'hA5);
    tx_wdata = 8'h96;
    pulse(tx_we);
    pulse(clock_release_set);
    i_i2css_master.recv_byte(got, 1'b1);
    `CHK("tx byte 1", 8'h96, got)
    `CHK("irq tx", 1'b1, status.irq)
    pulse(irq_clear);
    tx_wdata = 8'h5A;
    pulse(tx_we);
    pulse(clock_release_set);
    i_i2css_master.recv_byte(got, 1'b0);
    `CHK("tx byte 2", 8'h5A, got)
    repeat (20) cyc();
    `CHK("read_write after nack", 1'b0, status.read_write)
    `CHK("scl free after nack", 1'b1, scl_oe_n)
    i_i2css_master.stop_cond();
  endtask
  task automatic t_ten();
    port_mode_select = `I2CSS_MODE_SLV10;
    set_addr(8'hF2);
    i_i2css_master.start_cond();
    i_i2css_master.send_byte(8'hF2, ack);
    `CHK("high byte ack", 1'b1, ack)
    `CHK("addr_update", 1'b1, status.addr_update)
    repeat (10) cyc();
    `CHK("scl held", 1'b0, scl_oe_n)
    read_buf(8'hF2);
    set_addr(8'h5A);
    `CHK("update cleared", 1'b0, status.addr_update)
    repeat (4) cyc();
    `CHK("scl freed", 1'b1, scl_oe_n)
    i_i2css_master.send_byte(8'h5A, ack);
    `CHK("low byte ack", 1'b1, ack)
    `CHK("addr_update low", 1'b1, status.addr_update)
    read_buf(8'h5A);
    set_addr(8'hF2);
    `CHK("update cleared low", 1'b0, status.addr_update)
    i_i2css_master.send_byte(8'hC3, ack);
    `CHK("ten data ack", 1'b1, ack)
    read_buf(8'hC3);
    i_i2css_master.stop_cond();
  endtask
  task automatic t_modes();
    logic [3:0] modes [3];
    modes = '{`I2CSS_MODE_FWM_IDLE, `I2CSS_MODE_SLV7_SP, `I2CSS_MODE_SLV10_SP};
    foreach (modes[m]) begin
      port_mode_select = modes[m];
      pulse(irq_clear);
      i_i2css_master.start_cond();
      `CHK("irq on start", 1'b1, status.irq)
      pulse(irq_clear);
      i_i2css_master.stop_cond();
      `CHK("irq on stop", 1'b1, status.irq)
    end
    port_mode_select = `I2CSS_MODE_FWM_IDLE;
    set_addr(8'hA5);
    i_i2css_master.start_cond();
    i_i2css_master.send_byte(8'hA4, ack);
    `CHK("idle slave ack", 1'b0, ack)
    i_i2css_master.stop_cond();
    `CHK("idle slave buf", 1'b0, status.buf_full)
  endtask
  task automatic t_disable();
    port_enable_bit = 1'b0;
    repeat (3) cyc();
    `CHK("start_seen off", 1'b0, status.start_seen)
    `CHK("stop_seen off", 1'b0, status.stop_seen)
    port_enable_bit = 1'b1;
  endtask
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    port_enable_bit = 1'b1;
    port_mode_select = `I2CSS_MODE_SLV7;
    {own_address_we, tx_we, clock_release_set, irq_clear, overflow_clear, rx_ready} = 6'h00;
    own_address_wdata = 8'h00;
    tx_wdata = 8'h00;
    n_fail = 0;
    tests_run = 0;
    cycles = 0;
    repeat (2) @(posedge clk);
    #1;
    reset_n = 1'b1;
    repeat (4) cyc();
    `CHK("status after reset", 8'h01, status)
    `CHK("scl_oe_n after reset", 1'b1, scl_oe_n)
    t_write();
    t_mismatch();
    t_read();
    t_ten();
    t_modes();
    t_disable();
    `CHK("bus stuck", 0, i_i2css_master.stuck)
    give_verdict();
  end
endmodule
